// ===== rtl/gpf_pkg.sv
package gpf_pkg;

  // ==========================================================
  // Register indices
  localparam logic [7:0] GPF_OFS_MODE3 = 8'h5A;
  localparam logic [7:0] GPF_OFS_MODE4 = 8'h5B;
  localparam logic [7:0] GPF_OFS_PORTA = 8'h5C;
  localparam logic [7:0] GPF_OFS_PORTB = 8'h5D;
  localparam logic [7:0] GPF_OFS_IRQ_STAT = 8'h70;
  localparam logic [7:0] GPF_OFS_IRQ_EN = 8'h71;
  localparam logic [7:0] GPF_OFS_IRQ_CLR = 8'h72;

  // ==========================================================
  // Field positions
  localparam int GPF_MODE4_SEL1_BIT = 7;
  localparam int GPF_MODE4_F1_LSB = 4;
  localparam int GPF_MODE4_RSV_BIT = 3;
  localparam int GPF_MODE4_F0_LSB = 0;
  localparam int GPF_MODE3_SEL2_BIT = 3;
  localparam int GPF_MODE3_F2_LSB = 0;

  // ==========================================================
  // Interrupt event bits
  localparam int GPF_EV_PIN1 = 0;
  localparam int GPF_EV_PIN2 = 1;
  localparam int GPF_EV_WDISC = 2;
  localparam int GPF_EV_W = 3;

  // ==========================================================
  // Reset values
  localparam logic [2:0] GPF_FUNC_RST = 3'h0;
  localparam logic GPF_SEL_RST = 1'b0;
  localparam logic [7:0] GPF_DATA_RST = 8'h00;
  localparam logic [GPF_EV_W-1:0] GPF_EV_RST = 3'h0;

  // ==========================================================
  // Pin function codes
  typedef enum logic [2:0] {
    GPF_FN_GP_IN = 3'h0,
    GPF_FN_IRQ = 3'h1,
    GPF_FN_ALT_IN = 3'h2,
    GPF_FN_RET = 3'h3,
    GPF_FN_GP_OUT = 3'h4,
    GPF_FN_ALT5 = 3'h5,
    GPF_FN_ALT6 = 3'h6,
    GPF_FN_SCAN = 3'h7
  } gpf_func_t;

  // Per-pin reserved code masks, bit n set marks code n reserved
  localparam logic [7:0] GPF_RSV_PIN0 = 8'h06;
  localparam logic [7:0] GPF_RSV_PIN12 = 8'h20;

  function automatic logic gpf_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

endpackage

// ===== rtl/gpf_port_data.sv
`timescale 1ns/1ps
module gpf_port_data
  import gpf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] gp_in_mask,
  input wire logic [7:0] gp_out_mask,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] rd_val,
  output logic discard
);

  logic [7:0] data_q;

  // ==========================================================
  // Data bits, one flop per pin
  genvar i;
  for (i = 0; i < 8; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        data_q[i] <= GPF_DATA_RST[i];
      end else if (wr_en && gp_out_mask[i]) begin
        data_q[i] <= wdata[i]; // R10 R13 R14 R15
      end
    end
  end

  // ==========================================================
  // Pin drive and read value
  assign pin_out = data_q; // R10
  assign pin_oe_n = ~gp_out_mask;
  assign rd_val = (gp_out_mask & data_q) | (gp_in_mask & ~gp_out_mask & pin_in); // R11 R12 R14
  assign discard = wr_en && (gp_out_mask != 8'hFF);

endmodule

// ===== rtl/gpf_pinc_mux.sv
`timescale 1ns/1ps
module gpf_pinc_mux
  import gpf_pkg::*;
#(
  parameter logic [7:0] RSV_MASK = 8'h20
) (
  input wire logic [2:0] func,
  input wire logic gp_out_val,
  input wire logic alt_out_val,
  input wire logic scan_bit,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic ret_bit
);

  logic rsv;

  assign rsv = RSV_MASK[func];

  // ==========================================================
  // Output driver per function code
  always_comb begin
    pin_out = 1'b0;
    pin_oe_n = 1'b1; // R19
    if (!rsv) begin
      unique case (gpf_func_t'(func))
        GPF_FN_GP_IN, GPF_FN_IRQ, GPF_FN_ALT_IN, GPF_FN_RET: begin
          pin_oe_n = 1'b1; // R19
        end
        GPF_FN_GP_OUT: begin
          pin_out = gp_out_val;
          pin_oe_n = 1'b0;
        end
        GPF_FN_ALT5, GPF_FN_ALT6: begin
          pin_out = alt_out_val;
          pin_oe_n = 1'b0;
        end
        GPF_FN_SCAN: begin
          pin_out = 1'b0;
          pin_oe_n = ~scan_bit; // R16
        end
      endcase
    end
  end

  assign ret_bit = (func == GPF_FN_RET) ? pin_in : 1'b1; // R17

endmodule

// ===== rtl/gpf_pin_function_and_data.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
// Operation
// R01 - Pin C2 codes: gp in, irq, battery sense, return_status_bit_18, gp out, rsv, cs1, key_scan_drive_18.
// R02 - Pin C2 irq code routes to irq6 when select set, else irq14.
// R03 - Pin C1 select clear (reset) routes to irq15, set routes to irq7.
// R04 - Pin C1 select matters only while its function code is 001.
// R05 - Pin C1 codes: gp in, irq, serial rx, return_status_bit_17, gp out, rsv, cs0, key_scan_drive_17.
// R06 - Pin C0 codes: gp in, rsv, rsv, return_status_bit_16, gp out, frame polarity, ale, key_scan_drive_16.
// R07 - Mode register 4: bit7 C1 select, 6:4 C1 function, 3 reserved, 2:0 C0.
// R08 - Reserved bit 3 of mode register 4 resets to zero.
// R09 - Every pin function field resets to 000, general input.
// R10 - Data register write drives written bits onto general output pins.
// R11 - Output pin data bits read back the last written value.
// R12 - Input pin data bits read the current pin level.
// R13 - Writes to input pin data bits are discarded.
// R14 - Bits of pins neither gp input nor output ignore writes, read zero.
// R15 - Port A and B data registers are 8 bits, bit n is pin n.
// R16 - Scan function: pin floats when scan bit 0, driven low when 1.
// R17 - Return-status function shows pin level; unassigned status bits read one.
// R18 - Pin C2 select sits at bit 3 of mode register 3, resets zero.
// R19 - Input or reserved function codes leave the pin undriven.
module gpf_pin_function_and_data
  import gpf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] port_a_gp_in_mask,
  input wire logic [7:0] port_a_gp_out_mask,
  input wire logic [7:0] port_a_pin_in,
  output logic [7:0] port_a_pin_out,
  output logic [7:0] port_a_pin_oe_n,
  input wire logic [7:0] port_b_gp_in_mask,
  input wire logic [7:0] port_b_gp_out_mask,
  input wire logic [7:0] port_b_pin_in,
  output logic [7:0] port_b_pin_out,
  output logic [7:0] port_b_pin_oe_n,
  input wire logic [2:0] portc_pin_in,
  output logic [2:0] portc_pin_out,
  output logic [2:0] portc_pin_oe_n,
  input wire logic [2:0] portc_gp_out_data,
  output logic [2:0] portc_gp_in_sel,
  output logic [2:0] portc_gp_out_sel,
  input wire logic [2:0] key_scan_ctrl,
  input wire logic chip_select_0,
  input wire logic chip_select_1,
  input wire logic display_frame_polarity,
  input wire logic card_addr_latch_en,
  output logic [2:0] return_status_bits,
  output logic battery_sense_two,
  output logic aux_serial_receive,
  output logic irq6,
  output logic irq7,
  output logic irq14,
  output logic irq15,
  output logic irq_out
);

  // ==========================================================
  // Configuration state
  logic [2:0] portc_pin0_function;
  logic [2:0] portc_pin1_function;
  logic [2:0] portc_pin2_function;
  logic portc_pin1_irq_select;
  logic portc_pin2_irq_select;
  logic [GPF_EV_W-1:0] irq_stat_q;
  logic [GPF_EV_W-1:0] irq_en_q;
  logic [GPF_EV_W-1:0] irq_ev;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [7:0] port_a_rd_val;
  logic [7:0] port_b_rd_val;
  logic wr_a;
  logic wr_b;
  logic disc_a;
  logic disc_b;
  logic pin1_irq_lvl;
  logic pin2_irq_lvl;
  logic pin1_irq_q;
  logic pin2_irq_q;
  logic [2:0] alt_out;
  logic [2:0] fn_is_gp_in;

  // ==========================================================
  // Mode register 4
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      portc_pin1_irq_select <= GPF_SEL_RST; // R03
      portc_pin1_function <= GPF_FUNC_RST; // R09
      portc_pin0_function <= GPF_FUNC_RST; // R09
    end else if (reg_wr && gpf_hit(reg_addr, GPF_OFS_MODE4)) begin
      portc_pin1_irq_select <= reg_wdata[GPF_MODE4_SEL1_BIT]; // R07
      portc_pin1_function <= reg_wdata[GPF_MODE4_F1_LSB +: 3]; // R07
      portc_pin0_function <= reg_wdata[GPF_MODE4_F0_LSB +: 3]; // R07
    end
  end

  // ==========================================================
  // Mode register 3, low nibble (pin C2)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      portc_pin2_irq_select <= GPF_SEL_RST; // R18
      portc_pin2_function <= GPF_FUNC_RST; // R09
    end else if (reg_wr && gpf_hit(reg_addr, GPF_OFS_MODE3)) begin
      portc_pin2_irq_select <= reg_wdata[GPF_MODE3_SEL2_BIT]; // R18
      portc_pin2_function <= reg_wdata[GPF_MODE3_F2_LSB +: 3];
    end
  end

  // ==========================================================
  // Port A and port B data
  assign wr_a = reg_wr && gpf_hit(reg_addr, GPF_OFS_PORTA);
  assign wr_b = reg_wr && gpf_hit(reg_addr, GPF_OFS_PORTB);

  gpf_port_data u_port_a (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_a),
    .wdata(reg_wdata),
    .gp_in_mask(port_a_gp_in_mask),
    .gp_out_mask(port_a_gp_out_mask),
    .pin_in(port_a_pin_in),
    .pin_out(port_a_pin_out),
    .pin_oe_n(port_a_pin_oe_n),
    .rd_val(port_a_rd_val),
    .discard(disc_a)
  );

  gpf_port_data u_port_b (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_b),
    .wdata(reg_wdata),
    .gp_in_mask(port_b_gp_in_mask),
    .gp_out_mask(port_b_gp_out_mask),
    .pin_in(port_b_pin_in),
    .pin_out(port_b_pin_out),
    .pin_oe_n(port_b_pin_oe_n),
    .rd_val(port_b_rd_val),
    .discard(disc_b)
  );

  // ==========================================================
  // Port C pin muxes
  assign alt_out[0] = (portc_pin0_function == GPF_FN_ALT5) ?
                      display_frame_polarity : card_addr_latch_en; // R06
  assign alt_out[1] = chip_select_0; // R05
  assign alt_out[2] = chip_select_1; // R01

  gpf_pinc_mux #(.RSV_MASK(GPF_RSV_PIN0)) u_pin0 (
    .func(portc_pin0_function),
    .gp_out_val(portc_gp_out_data[0]),
    .alt_out_val(alt_out[0]),
    .scan_bit(key_scan_ctrl[0]),
    .pin_in(portc_pin_in[0]),
    .pin_out(portc_pin_out[0]),
    .pin_oe_n(portc_pin_oe_n[0]),
    .ret_bit(return_status_bits[0])
  );

  gpf_pinc_mux #(.RSV_MASK(GPF_RSV_PIN12)) u_pin1 (
    .func(portc_pin1_function),
    .gp_out_val(portc_gp_out_data[1]),
    .alt_out_val(alt_out[1]),
    .scan_bit(key_scan_ctrl[1]),
    .pin_in(portc_pin_in[1]),
    .pin_out(portc_pin_out[1]),
    .pin_oe_n(portc_pin_oe_n[1]),
    .ret_bit(return_status_bits[1])
  );

  gpf_pinc_mux #(.RSV_MASK(GPF_RSV_PIN12)) u_pin2 (
    .func(portc_pin2_function),
    .gp_out_val(portc_gp_out_data[2]),
    .alt_out_val(alt_out[2]),
    .scan_bit(key_scan_ctrl[2]),
    .pin_in(portc_pin_in[2]),
    .pin_out(portc_pin_out[2]),
    .pin_oe_n(portc_pin_oe_n[2]),
    .ret_bit(return_status_bits[2])
  );

  assign fn_is_gp_in = {portc_pin2_function == GPF_FN_GP_IN,
                        portc_pin1_function == GPF_FN_GP_IN,
                        portc_pin0_function == GPF_FN_GP_IN};
  assign portc_gp_in_sel = fn_is_gp_in;
  assign portc_gp_out_sel = {portc_pin2_function == GPF_FN_GP_OUT,
                             portc_pin1_function == GPF_FN_GP_OUT,
                             portc_pin0_function == GPF_FN_GP_OUT};

  // ==========================================================
  // Alternate inputs and interrupt steering
  assign battery_sense_two = (portc_pin2_function == GPF_FN_ALT_IN) && portc_pin_in[2]; // R01
  assign aux_serial_receive = (portc_pin1_function != GPF_FN_ALT_IN) || portc_pin_in[1]; // R05

  assign pin1_irq_lvl = (portc_pin1_function == GPF_FN_IRQ) && portc_pin_in[1]; // R04
  assign pin2_irq_lvl = (portc_pin2_function == GPF_FN_IRQ) && portc_pin_in[2];
  assign irq7 = pin1_irq_lvl && portc_pin1_irq_select; // R03
  assign irq15 = pin1_irq_lvl && !portc_pin1_irq_select; // R03
  assign irq6 = pin2_irq_lvl && portc_pin2_irq_select; // R02
  assign irq14 = pin2_irq_lvl && !portc_pin2_irq_select; // R02

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin1_irq_q <= 1'b0;
      pin2_irq_q <= 1'b0;
    end else begin
      pin1_irq_q <= pin1_irq_lvl;
      pin2_irq_q <= pin2_irq_lvl;
    end
  end

  // ==========================================================
  // Interrupt status, enable, clear
  assign irq_ev[GPF_EV_PIN1] = pin1_irq_lvl && !pin1_irq_q;
  assign irq_ev[GPF_EV_PIN2] = pin2_irq_lvl && !pin2_irq_q;
  assign irq_ev[GPF_EV_WDISC] = disc_a || disc_b; // R13

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= GPF_EV_RST;
    end else if (reg_wr && gpf_hit(reg_addr, GPF_OFS_IRQ_CLR)) begin
      irq_stat_q <= (irq_stat_q & ~reg_wdata[GPF_EV_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_q <= GPF_EV_RST;
    end else if (reg_wr && gpf_hit(reg_addr, GPF_OFS_IRQ_EN)) begin
      irq_en_q <= reg_wdata[GPF_EV_W-1:0];
    end
  end

  assign irq_out = |(irq_stat_q & irq_en_q);

  // ==========================================================
  // Read path, data valid the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (gpf_hit(reg_addr, GPF_OFS_MODE4)) begin
      rdata_d = {portc_pin1_irq_select, portc_pin1_function, 1'b0,
                 portc_pin0_function}; // R07 R08
    end else if (gpf_hit(reg_addr, GPF_OFS_MODE3)) begin
      rdata_d = {4'h0, portc_pin2_irq_select, portc_pin2_function}; // R18
    end else if (gpf_hit(reg_addr, GPF_OFS_PORTA)) begin
      rdata_d = port_a_rd_val; // R11 R12
    end else if (gpf_hit(reg_addr, GPF_OFS_PORTB)) begin
      rdata_d = port_b_rd_val; // R11 R12
    end else if (gpf_hit(reg_addr, GPF_OFS_IRQ_STAT)) begin
      rdata_d = {5'h00, irq_stat_q};
    end else if (gpf_hit(reg_addr, GPF_OFS_IRQ_EN)) begin
      rdata_d = {5'h00, irq_en_q};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  reset_fields_a: assert property ( // R09
    disable iff (1'b0) rst |=> (portc_pin0_function == 3'h0 && portc_pin1_function == 3'h0
      && portc_pin2_function == 3'h0 && !portc_pin2_irq_select && !portc_pin1_irq_select))
    else $error("function fields not cleared by reset");

  pin2_irq_route_a: assert property ( // R02
    portc_pin2_function == GPF_FN_IRQ |-> irq6 == (portc_pin2_irq_select && portc_pin_in[2])
      && irq14 == (!portc_pin2_irq_select && portc_pin_in[2]))
    else $error("pin C2 interrupt steering wrong");

  pin1_irq_route_a: assert property ( // R03
    portc_pin1_function == GPF_FN_IRQ && !portc_pin1_irq_select
      |-> irq15 == portc_pin_in[1] && !irq7)
    else $error("pin C1 default interrupt steering wrong");

  pin1_sel_inert_a: assert property ( // R04
    portc_pin1_function != GPF_FN_IRQ |-> !irq7 && !irq15)
    else $error("pin C1 select active outside interrupt function");

  mode4_layout_a: assert property ( // R07
    reg_wr && gpf_hit(reg_addr, GPF_OFS_MODE4) ##1 reg_rd && gpf_hit(reg_addr, GPF_OFS_MODE4)
      |=> reg_rdata == {$past(reg_wdata[7:4], 2), 1'b0, $past(reg_wdata[2:0], 2)})
    else $error("mode register 4 readback wrong");

  mode4_rsv_zero_a: assert property ( // R08
    reg_rd && gpf_hit(reg_addr, GPF_OFS_MODE4) |=> reg_rdata[GPF_MODE4_RSV_BIT] == 1'b0)
    else $error("reserved bit reads nonzero");

  gp_out_drive_a: assert property ( // R10
    wr_a && port_a_gp_out_mask[0] |=> port_a_pin_out[0] == $past(reg_wdata[0])
      && (port_a_pin_oe_n[0] == !port_a_gp_out_mask[0]))
    else $error("port A output not driven with written data");

  gp_out_read_a: assert property ( // R11
    wr_b && port_b_gp_out_mask == 8'hFF ##1 reg_rd && gpf_hit(reg_addr, GPF_OFS_PORTB)
      && port_b_gp_out_mask == 8'hFF |=> reg_rdata == $past(reg_wdata, 2))
    else $error("output data readback wrong");

  gp_in_read_a: assert property ( // R12
    reg_rd && gpf_hit(reg_addr, GPF_OFS_PORTA) && port_a_gp_in_mask == 8'hFF
      && port_a_gp_out_mask == 8'h00 |=> reg_rdata == $past(port_a_pin_in))
    else $error("input pin level not returned");

  wr_discard_a: assert property ( // R13
    wr_a && port_a_gp_out_mask != 8'hFF |=> irq_stat_q[GPF_EV_WDISC])
    else $error("discarded write not flagged");

  unassigned_zero_a: assert property ( // R14
    reg_rd && gpf_hit(reg_addr, GPF_OFS_PORTB)
      && (port_b_gp_in_mask | port_b_gp_out_mask) == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unassigned data bits read nonzero");

  scan_drive_a: assert property ( // R16
    portc_pin0_function == GPF_FN_SCAN
      |-> portc_pin_oe_n[0] == !key_scan_ctrl[0] && !portc_pin_out[0])
    else $error("scan pin drive wrong");

  ret_default_a: assert property ( // R17
    portc_pin2_function != GPF_FN_RET |-> return_status_bits[2])
    else $error("unassigned return status not one");

  input_float_a: assert property ( // R19
    !portc_pin1_function[2] || portc_pin1_function == GPF_FN_ALT5 |-> portc_pin_oe_n[1])
    else $error("input pin driven");

  irq_event_set_a: assert property (
    $rose(pin1_irq_lvl) |=> irq_stat_q[GPF_EV_PIN1])
    else $error("pin C1 interrupt event not latched");

  irq6_seen_c: cover property (portc_pin2_function == GPF_FN_IRQ && irq6);
  scan_low_c: cover property (portc_pin_oe_n[2] == 1'b0 && portc_pin2_function == GPF_FN_SCAN);
  wr_then_rd_c: cover property (wr_a ##1 reg_rd && gpf_hit(reg_addr, GPF_OFS_PORTA));
  irq_raise_c: cover property (!irq_out ##1 irq_out);

endmodule

// ===== test/gpf_pin_model.sv
`timescale 1ns/1ps
module gpf_pin_model (
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe_n,
  input wire logic [7:0] a_ext,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe_n,
  input wire logic [7:0] b_ext,
  input wire logic [2:0] c_out,
  input wire logic [2:0] c_oe_n,
  input wire logic [2:0] c_ext,
  output logic [7:0] a_pin,
  output logic [7:0] b_pin,
  output logic [2:0] c_pin
);
  // ==========================================================
  // Wire level: device drive wins, else outside level
  assign a_pin = (a_out & ~a_oe_n) | (a_ext & a_oe_n);
  assign b_pin = (b_out & ~b_oe_n) | (b_ext & b_oe_n);
  assign c_pin = (c_out & ~c_oe_n) | (c_ext & c_oe_n);
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import gpf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [7:0] a_in_m = 8'h00, a_out_m = 8'h00, b_in_m = 8'h00, b_out_m = 8'h00;
  logic [7:0] a_ext = 8'hFF, b_ext = 8'hFF, a_pin, b_pin, a_out, a_oe_n, b_out, b_oe_n;
  logic [2:0] c_ext = 3'h0, c_gpd = 3'h0, ks = 3'h0, c_pin, c_out, c_oe_n;
  logic [2:0] in_sel, out_sel, ret;
  logic cs0 = 1'b0, cs1 = 1'b0, dfp = 1'b0, ale = 1'b0;
  logic bat, aux, irq6, irq7, irq14, irq15, irq_out;
  int err_count = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;

  gpf_pin_function_and_data gpf_pin_function_and_data_inst (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_a_gp_in_mask(a_in_m), .port_a_gp_out_mask(a_out_m), .port_a_pin_in(a_pin),
    .port_a_pin_out(a_out), .port_a_pin_oe_n(a_oe_n),
    .port_b_gp_in_mask(b_in_m), .port_b_gp_out_mask(b_out_m), .port_b_pin_in(b_pin),
    .port_b_pin_out(b_out), .port_b_pin_oe_n(b_oe_n),
    .portc_pin_in(c_pin), .portc_pin_out(c_out), .portc_pin_oe_n(c_oe_n),
    .portc_gp_out_data(c_gpd), .portc_gp_in_sel(in_sel), .portc_gp_out_sel(out_sel),
    .key_scan_ctrl(ks), .chip_select_0(cs0), .chip_select_1(cs1),
    .display_frame_polarity(dfp), .card_addr_latch_en(ale),
    .return_status_bits(ret), .battery_sense_two(bat), .aux_serial_receive(aux),
    .irq6(irq6), .irq7(irq7), .irq14(irq14), .irq15(irq15), .irq_out(irq_out)
  );

  gpf_pin_model gpf_pin_model_inst (
    .a_out(a_out), .a_oe_n(a_oe_n), .a_ext(a_ext), .b_out(b_out), .b_oe_n(b_oe_n),
    .b_ext(b_ext), .c_out(c_out), .c_oe_n(c_oe_n), .c_ext(c_ext),
    .a_pin(a_pin), .b_pin(b_pin), .c_pin(c_pin)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    r = reg_rdata;
  endtask

  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] pout(input logic [7:0] ofs);
    return (ofs == GPF_OFS_PORTA) ? a_out : b_out;
  endfunction

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    #1;
    chk("c_oe_n", 8'(c_oe_n), 8'h07);
    chk("in_sel", 8'(in_sel), 8'h07);
    chk("ret", 8'(ret), 8'h07);
    chk("irq_out", 8'(irq_out), 8'h00);
    rd(GPF_OFS_MODE4, d);
    chk("mode4", d, 8'h00);
    settle();
    chk("rdata", reg_rdata, 8'h00);
    rd(GPF_OFS_MODE3, d);
    chk("mode3", d, 8'h00);
    rd(GPF_OFS_PORTA, d);
    chk("porta", d, 8'h00);
    wr_rd(GPF_OFS_MODE4, 8'hDB, d);
    chk("mode4", d, 8'hD3);
  endtask

  task automatic t_port(input logic [7:0] ofs);
    @(posedge clk);
    {a_in_m, b_in_m, a_out_m, b_out_m} <= {8'h30, 8'h30, 8'h0F, 8'h0F};
    {a_ext, b_ext} <= {8'hA5, 8'hA5};
    wr(ofs, 8'hFF);
    settle();
    chk("pin_out", pout(ofs) & 8'h0F, 8'h0F);
    chk("oe_n", (ofs == GPF_OFS_PORTA) ? a_oe_n : b_oe_n, 8'hF0);
    rd(ofs, d);
    chk("data", d, 8'h2F);
    @(posedge clk);
    {a_ext, b_ext} <= {8'h5A, 8'h5A};
    wr(ofs, 8'hC6);
    rd(ofs, d);
    chk("data", d, 8'h16);
    @(posedge clk);
    {a_in_m, b_in_m, a_out_m, b_out_m} <= {8'h00, 8'h00, 8'hFF, 8'hFF};
    settle();
    chk("pin_out", pout(ofs), 8'h06);
    rd(ofs, d);
    chk("data", d, 8'h06);
    wr_rd(ofs, 8'h3C, d);
    chk("data", d, 8'h3C);
    chk("pin_out", pout(ofs), 8'h3C);
    @(posedge clk);
    {a_in_m, b_in_m, a_out_m, b_out_m} <= {8'hFF, 8'hFF, 8'h00, 8'h00};
    rd(ofs, d);
    chk("data", d, 8'h5A);
    @(posedge clk);
    {a_in_m, b_in_m} <= {8'h00, 8'h00};
    rd(ofs, d);
    chk("data", d, 8'h00);
  endtask

  task automatic t_pinc;
    logic lv, sel, oe, po, rt;
    logic [2:0] c;
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 8; k++) begin
        c = 3'(k);
        sel = s[0];
        lv = s[1];
        @(posedge clk);
        c_ext <= {3{lv}};
        ks <= {sel, lv, sel};
        c_gpd <= {sel, ~sel, sel};
        {cs0, cs1, dfp, ale} <= {sel, ~sel, ~sel, sel};
        wr(GPF_OFS_MODE4, {sel, c, 1'b0, c});
        wr(GPF_OFS_MODE3, {4'h0, sel, c});
        settle();
        for (int p = 0; p < 3; p++) begin
          oe = 1'b1;
          po = 1'b0;
          rt = 1'b1;
          case (c)
            3'h3: rt = lv;
            3'h4: begin
              oe = 1'b0;
              po = c_gpd[p];
            end
            3'h5: if (p == 0) begin
              oe = 1'b0;
              po = dfp;
            end
            3'h6: begin
              oe = 1'b0;
              po = (p == 0) ? ale : (p == 1) ? cs0 : cs1;
            end
            3'h7: oe = ~ks[p];
            default: ;
          endcase
          chk("c_oe_n", 8'(c_oe_n[p]), 8'(oe));
          if (!oe) chk("c_out", 8'(c_out[p]), 8'(po));
          chk("ret", 8'(ret[p]), 8'(rt));
          chk("in_sel", 8'(in_sel[p]), 8'(c == 3'h0));
          chk("out_sel", 8'(out_sel[p]), 8'(c == 3'h4));
        end
        chk("irq", {4'h0, irq6, irq14, irq7, irq15}, {4'h0, c == 3'h1 && sel && lv,
            c == 3'h1 && !sel && lv, c == 3'h1 && sel && lv, c == 3'h1 && !sel && lv});
        chk("alt", {6'h00, bat, aux}, {6'h00, c == 3'h2 && lv, c == 3'h2 ? lv : 1'b1});
      end
    end
  endtask

  task automatic t_irq;
    wr(GPF_OFS_IRQ_CLR, 8'h07);
    @(posedge clk);
    c_ext <= 3'h0;
    wr(GPF_OFS_MODE4, 8'h10);
    wr(GPF_OFS_MODE3, 8'h00);
    wr(GPF_OFS_IRQ_EN, 8'h01);
    @(posedge clk);
    c_ext <= 3'h2;
    settle();
    settle();
    chk("irq15", 8'(irq15), 8'h01);
    chk("irq_out", 8'(irq_out), 8'h01);
    rd(GPF_OFS_IRQ_STAT, d);
    chk("status", d, 8'h01);
    wr(GPF_OFS_IRQ_EN, 8'h00);
    settle();
    chk("irq_out", 8'(irq_out), 8'h00);
    wr(GPF_OFS_IRQ_EN, 8'h01);
    settle();
    chk("irq_out", 8'(irq_out), 8'h01);
    wr(GPF_OFS_IRQ_CLR, 8'h01);
    settle();
    chk("irq_out", 8'(irq_out), 8'h00);
    @(posedge clk);
    c_ext <= 3'h0;
    wr(GPF_OFS_MODE3, 8'h09);
    @(posedge clk);
    c_ext <= 3'h4;
    settle();
    settle();
    chk("irq6", 8'(irq6), 8'h01);
    rd(GPF_OFS_IRQ_STAT, d);
    chk("status", d, 8'h02);
    wr(GPF_OFS_IRQ_CLR, 8'h07);
    @(posedge clk);
    a_out_m <= 8'h00;
    wr(GPF_OFS_PORTA, 8'h01);
    rd(GPF_OFS_IRQ_STAT, d);
    chk("status", d, 8'h04);
    wr(8'h40, 8'hFF);
    rd(8'h40, d);
    chk("unmapped", d, 8'h00);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_port(GPF_OFS_PORTA);
    t_port(GPF_OFS_PORTB);
    t_pinc();
    t_irq();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule
